// [hdl/charge_mode_controller.sv]
// Function
// - Input limit resets to 100 mA
// - Pin selects 100 or 500 mA
// - Programmed limit overrides pin from then on
// - Limit settings 100 to 1500 mA
// - Flag when limit starves charge current
// - Dead cell forces trickle mode and code
// - Trickle isolates battery, regulator holds system
// - Sixty minute trickle time-out gives fault
// - Between thresholds move to weak mode
// - Weak mode holds limit at 100 mA
// - Weak mode feeds 20 mA trickle branch
// - Above thresholds fast mode, code 010
`timescale 1ns/1ps
module charge_mode_controller
    import charger_pkg::*;
#(
    parameter logic [TMR_W-1:0] TRICKLE_CYCLES = TRICKLE_TIMEOUT_CYC
) (
    // System
    input wire logic clk_sys,
    input wire logic rst,
    // Pins from the analogue side
    input wire logic config_pin_one,
    input wire logic dead_cell_low,
    input wire logic weak_cell_low,
    // Charger controls and flags
    output logic [2:0] charge_state,
    output logic [MA_W-1:0] active_limit_ma,
    output logic [MA_W-1:0] main_charge_ma,
    output logic [MA_W-1:0] trickle_branch_ma,
    output logic iso_switch_on,
    output logic ldo_holds_system,
    output logic input_limited_flag,
    output logic irq,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Software state
    logic [INPUT_LIMIT_FIELD_W-1:0] input_limit_field, next_input_limit_field;
    logic prog, next_prog;
    cfg_t cfg, next_cfg;
    logic [MA_W-1:0] fast_ma, next_fast_ma;
    logic [DEAD_W-1:0] dead_ma, next_dead_ma;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [IRQ_W-1:0] irq_mask, next_irq_mask;
    logic [IRQ_W-1:0] irq_evt;
    logic next_irq;
    // Bus slave state
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic aw_full, next_aw_full;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic w_full, next_w_full;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [31:0] wr_word;
    logic [IRQ_W-1:0] irq_clr;
    // Charger state
    chg_state_t st, next_st, cmp_st;
    cmp_t cmp_s;
    logic pin_s;
    logic tmr_done;
    logic [INPUT_LIMIT_FIELD_W-1:0] eff_code;
    logic [MA_W-1:0] lim_ma;
    logic [2:0] next_charge_state;
    logic [MA_W-1:0] next_main_ma, next_branch_ma;
    logic next_iso_on, next_ldo_holds, next_limited;

    // Comparators and pin filtered before use
    pin_sync #(.W(3)) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .d({dead_cell_low, weak_cell_low, config_pin_one}),
        .q({cmp_s, pin_s})
    );

    trickle_timer #(.LIMIT(TRICKLE_CYCLES)) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(st == ST_TRICKLE),
        .done(tmr_done)
    );

    // Word-aligned register decode, shared by read and write
    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
        return {a[ADDR_W-1:2], 2'h0};
    endfunction : word_addr

    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        case (word_addr(a))
            ADDR_CTRL, ADDR_CONFIG, ADDR_CURRENT, ADDR_STATUS,
            ADDR_IRQ_STAT, ADDR_IRQ_MASK: return 1'h1;
            default: return 1'h0;
        endcase
    endfunction : addr_ok

    function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0;
        case (word_addr(a))
            ADDR_CTRL: w[INPUT_LIMIT_FIELD_LSB +: INPUT_LIMIT_FIELD_W] = input_limit_field;
            ADDR_CONFIG: w[CFG_LSB +: CFG_W] = cfg;
            ADDR_CURRENT: begin
                w[FAST_LSB +: MA_W] = fast_ma;
                w[DEAD_LSB +: DEAD_W] = dead_ma;
            end
            ADDR_STATUS: begin
                w[ST_CODE_LSB +: 3] = charge_state;
                w[ST_LIMITED_BIT] = input_limited_flag;
                w[ST_PROG_BIT] = prog;
                w[ST_PIN_BIT] = pin_s;
                w[ST_LIMIT_LSB +: MA_W] = active_limit_ma;
            end
            ADDR_IRQ_STAT: w[IRQ_W-1:0] = irq_stat;
            ADDR_IRQ_MASK: w[IRQ_W-1:0] = irq_mask;
            default: w = 32'h0;
        endcase
        return w;
    endfunction : reg_word

    // Bus slave and register writes; one write and one read in flight
    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_full = aw_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_full = w_full;
        next_awready = awready;
        next_wready = wready;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_input_limit_field = input_limit_field;
        next_prog = prog;
        next_cfg = cfg;
        next_fast_ma = fast_ma;
        next_dead_ma = dead_ma;
        next_irq_mask = irq_mask;
        irq_clr = '0;
        wr_word = byte_merge(reg_word(aw_addr), w_data, w_strb);
        if (awvalid && awready) begin
            next_aw_addr = awaddr;
            next_aw_full = 1'h1;
            next_awready = 1'h0;
        end
        if (wvalid && wready) begin
            next_w_data = wdata;
            next_w_strb = wstrb;
            next_w_full = 1'h1;
            next_wready = 1'h0;
        end
        // Address and data may arrive in either order
        if (aw_full && w_full && !bvalid) begin
            next_aw_full = 1'h0;
            next_w_full = 1'h0;
            next_bvalid = 1'h1;
            next_bresp = addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            case (word_addr(aw_addr))
                ADDR_CTRL: begin
                    // Unused codes are dropped rather than stored
                    if (w_strb[0] && wr_word[INPUT_LIMIT_FIELD_LSB +: INPUT_LIMIT_FIELD_W] <= INPUT_LIMIT_FIELD_1500) begin
                        next_input_limit_field = wr_word[INPUT_LIMIT_FIELD_LSB +: INPUT_LIMIT_FIELD_W];
                        next_prog = 1'h1;
                    end
                end
                ADDR_CONFIG: next_cfg = cfg_t'(wr_word[CFG_LSB +: CFG_W]);
                ADDR_CURRENT: begin
                    next_fast_ma = wr_word[FAST_LSB +: MA_W];
                    next_dead_ma = wr_word[DEAD_LSB +: DEAD_W];
                end
                ADDR_IRQ_STAT: irq_clr = w_strb[0] ? w_data[IRQ_W-1:0] : '0;  // Write one to clear
                ADDR_STATUS: next_bresp = RESP_OKAY;  // Read-only, write ignored
                ADDR_IRQ_MASK: next_irq_mask = wr_word[IRQ_W-1:0];
                default: next_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid && bready) begin
            next_bvalid = 1'h0;
            next_awready = 1'h1;
            next_wready = 1'h1;
        end
        if (arvalid && arready) begin
            next_arready = 1'h0;
            next_rvalid = 1'h1;
            next_rdata = reg_word(araddr);
            next_rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'h0;
            next_arready = 1'h1;
        end
        // A new event beats a clear in the same cycle
        next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_addr <= '0;
            aw_full <= 1'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            w_full <= 1'h0;
            awready <= 1'h1;
            wready <= 1'h1;
            bvalid <= 1'h0;
            bresp <= RESP_OKAY;
            arready <= 1'h1;
            rvalid <= 1'h0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
            input_limit_field <= INPUT_LIMIT_FIELD_100;
            prog <= 1'h0;
            cfg <= '{chg_en: 1'h1, pin_sel: 1'h1};
            fast_ma <= FAST_MA_RST;
            dead_ma <= DEAD_MA_RST;
            irq_stat <= '0;
            irq_mask <= IRQ_MASK_RST;
            irq <= 1'h0;
        end else begin
            aw_addr <= next_aw_addr;
            aw_full <= next_aw_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_full <= next_w_full;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            input_limit_field <= next_input_limit_field;
            prog <= next_prog;
            cfg <= next_cfg;
            fast_ma <= next_fast_ma;
            dead_ma <= next_dead_ma;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
        end
    end

    // Mode from thresholds; fault holds until charging is disabled
    always_comb begin
        if (cmp_s.dead_low) begin
            cmp_st = ST_TRICKLE;
        end else if (cmp_s.weak_low) begin
            cmp_st = ST_WEAK;
        end else begin
            cmp_st = ST_FAST;
        end
        next_st = cmp_st;
        if (!cfg.chg_en) begin
            next_st = ST_OFF;
        end else if (st == ST_FAULT) begin
            next_st = ST_FAULT;
        end else if (st == ST_TRICKLE && tmr_done && cmp_s.dead_low) begin
            next_st = ST_FAULT;
        end
    end

    // Limit choice: weak mode, then programmed value, then pin
    always_comb begin
        if (st == ST_WEAK) begin
            eff_code = INPUT_LIMIT_FIELD_100;
        end else if (prog || !cfg.pin_sel) begin
            eff_code = input_limit_field;
        end else begin
            eff_code = pin_s ? INPUT_LIMIT_FIELD_500 : INPUT_LIMIT_FIELD_100;
        end
        lim_ma = input_limit_field_ma(eff_code);
    end

    // Per-mode drive of the power path
    always_comb begin
        next_main_ma = '0;
        next_branch_ma = '0;
        next_iso_on = 1'h1;
        next_ldo_holds = 1'h1;
        next_limited = 1'h0;
        unique case (st)
            ST_OFF: next_charge_state = CS_OFF;
            ST_TRICKLE: begin
                next_charge_state = CS_TRICKLE;
                next_branch_ma = {3'h0, dead_ma};
                next_iso_on = 1'h0;
            end
            ST_WEAK: begin
                next_charge_state = CS_WEAK;
                next_branch_ma = WEAK_BRANCH_MA;
                next_main_ma = lim_ma - WEAK_BRANCH_MA;
                next_ldo_holds = 1'h0;
            end
            ST_FAST: begin
                next_charge_state = CS_FAST;
                next_ldo_holds = 1'h0;
                next_limited = lim_ma < fast_ma;
                next_main_ma = next_limited ? lim_ma : fast_ma;
            end
            ST_FAULT: next_charge_state = CS_FAULT;
            default: next_charge_state = CS_FAULT;
        endcase
        irq_evt = '0;
        irq_evt[IRQ_MODE_BIT] = next_st != st;
        irq_evt[IRQ_FAULT_BIT] = next_st == ST_FAULT && st != ST_FAULT;
        irq_evt[IRQ_LIMIT_BIT] = next_limited && !input_limited_flag;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= ST_OFF;
            charge_state <= CS_OFF;
            active_limit_ma <= MA_100;
            main_charge_ma <= '0;
            trickle_branch_ma <= '0;
            iso_switch_on <= 1'h1;
            ldo_holds_system <= 1'h1;
            input_limited_flag <= 1'h0;
        end else begin
            st <= next_st;
            charge_state <= next_charge_state;
            active_limit_ma <= lim_ma;
            main_charge_ma <= next_main_ma;
            trickle_branch_ma <= next_branch_ma;
            iso_switch_on <= next_iso_on;
            ldo_holds_system <= next_ldo_holds;
            input_limited_flag <= next_limited;
        end
    end

    sequence s_timeout;
        st == ST_TRICKLE && tmr_done && cfg.chg_en && cmp_s.dead_low;
    endsequence
    sequence s_fault_shown;
        st == ST_FAULT ##1 charge_state == CS_FAULT;
    endsequence

    chk_reset_limit: assert property (!prog |-> input_limit_field == INPUT_LIMIT_FIELD_100)
        else $error("limit field left default value without a write");
    chk_pin_limit: assert property (
        st == ST_FAST && cfg.pin_sel && !prog
        |=> active_limit_ma == ($past(pin_s) ? MA_500 : MA_100))
        else $error("pin-selected limit wrong");
    chk_prog_limit: assert property (
        st == ST_FAST && prog |=> active_limit_ma == input_limit_field_ma($past(input_limit_field)))
        else $error("programmed limit not applied");
    chk_limited_flag: assert property (
        st == ST_FAST && lim_ma < fast_ma |=> input_limited_flag)
        else $error("input limited flag missing");
    chk_dead_trickle: assert property (
        cmp_s.dead_low && cfg.chg_en && st != ST_FAULT && !tmr_done
        |=> st == ST_TRICKLE ##1 charge_state == CS_TRICKLE)
        else $error("dead cell not in trickle");
    chk_trickle_iso: assert property (
        st == ST_TRICKLE |=> !iso_switch_on && ldo_holds_system)
        else $error("battery not isolated in trickle");
    chk_trickle_fault: assert property (s_timeout |=> s_fault_shown)
        else $error("trickle time-out gave no fault");
    chk_weak_limit: assert property (
        st == ST_WEAK |=> active_limit_ma == MA_100 && trickle_branch_ma == WEAK_BRANCH_MA)
        else $error("weak mode limit or branch wrong");
    chk_weak_entry: assert property (
        !cmp_s.dead_low && cmp_s.weak_low && cfg.chg_en && st != ST_FAULT
        |=> st == ST_WEAK)
        else $error("weak mode not entered");
    chk_fast_code: assert property (
        st == ST_FAST |=> charge_state == CS_FAST)
        else $error("fast mode code wrong");

endmodule : charge_mode_controller

// [hdl/charger_pkg.sv]
package charger_pkg;

    // Clock and trickle time-out
    localparam longint unsigned CLK_PERIOD_NS = 64'd100;
    localparam longint unsigned TRICKLE_TIMEOUT_MIN = 64'd60;
    localparam longint unsigned NS_PER_MIN = 64'd60_000_000_000;
    localparam int TMR_W = 36;
    // A longest time, so the division rounds down
    localparam logic [TMR_W-1:0] TRICKLE_TIMEOUT_CYC =
        TMR_W'(TRICKLE_TIMEOUT_MIN * NS_PER_MIN / CLK_PERIOD_NS);

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CURRENT = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h14;

    // Field layout
    localparam int INPUT_LIMIT_FIELD_LSB = 0;
    localparam int INPUT_LIMIT_FIELD_W = 3;
    localparam int CFG_LSB = 0;
    localparam int CFG_W = 2;
    localparam int MA_W = 11;
    localparam int FAST_LSB = 0;
    localparam int DEAD_LSB = 16;
    localparam int DEAD_W = 8;
    localparam int ST_CODE_LSB = 0;
    localparam int ST_LIMITED_BIT = 3;
    localparam int ST_PROG_BIT = 4;
    localparam int ST_PIN_BIT = 5;
    localparam int ST_LIMIT_LSB = 16;
    localparam int IRQ_W = 3;
    localparam int IRQ_MODE_BIT = 0;
    localparam int IRQ_FAULT_BIT = 1;
    localparam int IRQ_LIMIT_BIT = 2;

    // Reset values
    localparam logic [MA_W-1:0] FAST_MA_RST = 11'h1F4;
    localparam logic [DEAD_W-1:0] DEAD_MA_RST = 8'h14;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // Input limit codes and their currents in mA
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_100 = 3'h0;
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_150 = 3'h1;
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_300 = 3'h2;
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_500 = 3'h3;
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_900 = 3'h4;
    localparam logic [INPUT_LIMIT_FIELD_W-1:0] INPUT_LIMIT_FIELD_1500 = 3'h5;
    localparam logic [MA_W-1:0] MA_100 = 11'h064;
    localparam logic [MA_W-1:0] MA_150 = 11'h096;
    localparam logic [MA_W-1:0] MA_300 = 11'h12C;
    localparam logic [MA_W-1:0] MA_500 = 11'h1F4;
    localparam logic [MA_W-1:0] MA_900 = 11'h384;
    localparam logic [MA_W-1:0] MA_1500 = 11'h5DC;
    localparam logic [MA_W-1:0] WEAK_BRANCH_MA = 11'h014;

    // Charge state codes, all distinct
    localparam logic [2:0] CS_OFF = 3'h0;
    localparam logic [2:0] CS_TRICKLE = 3'h1;
    localparam logic [2:0] CS_FAST = 3'h2;
    localparam logic [2:0] CS_WEAK = 3'h3;
    localparam logic [2:0] CS_FAULT = 3'h6;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {ST_OFF, ST_TRICKLE, ST_WEAK, ST_FAST, ST_FAULT} chg_state_t;

    // Synchronised threshold comparators
    typedef struct packed {
        logic dead_low;
        logic weak_low;
    } cmp_t;

    // Software configuration bits
    typedef struct packed {
        logic chg_en;
        logic pin_sel;
    } cfg_t;

    // Limit code to mA; unused codes fall back to the safe minimum
    function automatic logic [MA_W-1:0] input_limit_field_ma(input logic [INPUT_LIMIT_FIELD_W-1:0] code);
        case (code)
            INPUT_LIMIT_FIELD_150: input_limit_field_ma = MA_150;
            INPUT_LIMIT_FIELD_300: input_limit_field_ma = MA_300;
            INPUT_LIMIT_FIELD_500: input_limit_field_ma = MA_500;
            INPUT_LIMIT_FIELD_900: input_limit_field_ma = MA_900;
            INPUT_LIMIT_FIELD_1500: input_limit_field_ma = MA_1500;
            default: input_limit_field_ma = MA_100;
        endcase
    endfunction : input_limit_field_ma

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
        input logic [31:0] new_w, input logic [3:0] strb);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return m;
    endfunction : byte_merge

endpackage : charger_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
    import charger_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Raw pins and filtered result
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // A change only counts once the second and third stage agree
    always_comb begin
        next_q = q;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s3[i];
            end
        end
    end

    // First stage is read by the second only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

endmodule : pin_sync

// [hdl/trickle_timer.sv]
`timescale 1ns/1ps
module trickle_timer
    import charger_pkg::*;
#(
    parameter logic [TMR_W-1:0] LIMIT = TRICKLE_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Run while high, cleared while low
    input wire logic run,
    output logic done
);

    logic [TMR_W-1:0] count;
    logic [TMR_W-1:0] next_count;

    // Saturates at the limit so done stays up until run drops
    always_comb begin
        next_count = count;
        if (!run) begin
            next_count = '0;
        end else if (count != LIMIT) begin
            next_count = count + TMR_W'(1);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign done = run && (count == LIMIT);

endmodule : trickle_timer

// [sim/battery_model.sv]
`timescale 1ns/1ps
module battery_model (
    // Cell level: 0 dead, 1 weak, 2 good
    input wire logic [1:0] level,
    // Threshold comparators
    output logic dead_cell_low,
    output logic weak_cell_low
);
    // Comparators are plain levels; weak is also low when the cell is dead
    assign dead_cell_low = (level == 2'h0);
    assign weak_cell_low = (level != 2'h2);
endmodule : battery_model

// [sim/tb_charge_mode_controller.sv]
`timescale 1ns/1ps
module tb_charge_mode_controller;
    import charger_pkg::*;
    logic clk_sys, rst, config_pin_one, dead_cell_low, weak_cell_low, iso_switch_on;
    logic ldo_holds_system, input_limited_flag, irq, awvalid, awready, wvalid, wready;
    logic bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] level, bresp, rresp, resp;
    logic [2:0] charge_state;
    logic [MA_W-1:0] active_limit_ma, main_charge_ma, trickle_branch_ma;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0] wstrb;
    int n_fail, num_checks, prog, code;
    int lim_tab[6] = '{100, 150, 300, 500, 900, 1500};

    // Short trickle time-out keeps the run brief
    charge_mode_controller #(.TRICKLE_CYCLES(36'd50)) charge_mode_controller_inst (
        .clk_sys(clk_sys), .rst(rst), .config_pin_one(config_pin_one),
        .dead_cell_low(dead_cell_low), .weak_cell_low(weak_cell_low),
        .charge_state(charge_state), .active_limit_ma(active_limit_ma),
        .main_charge_ma(main_charge_ma), .trickle_branch_ma(trickle_branch_ma),
        .iso_switch_on(iso_switch_on), .ldo_holds_system(ldo_holds_system),
        .input_limited_flag(input_limited_flag), .irq(irq), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    battery_model battery_model_inst (.level(level), .dead_cell_low(dead_cell_low),
        .weak_cell_low(weak_cell_low));

    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %0t got %0h expected %0h", $time, g, e);
        end
    endtask : chk

    // Handshakes judged at the falling edge, acted on at the next rising edge
    task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic ha, hw, hb, done;
        done = 1'b0;
        @(posedge clk_sys);  // Drive just after an edge, never twice in one step
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clk_sys);
            ha = awvalid & awready; hw = wvalid & wready; hb = bvalid;
            @(posedge clk_sys);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) begin
                bready <= 1'b0; resp = bresp; done = 1'b1;
            end
        end
        if (!done) begin
            n_fail++;
            close_out();
        end
    endtask : wr

    task rd(input logic [ADDR_W-1:0] a);
        logic ha, done;
        done = 1'b0;
        @(posedge clk_sys);  // Drive just after an edge, never twice in one step
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clk_sys);
            ha = arvalid & arready;
            if (rvalid) begin
                rd_data = rdata; resp = rresp; done = 1'b1;
            end
            @(posedge clk_sys);
            if (ha) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) begin
            n_fail++;
            close_out();
        end
    endtask : rd

    // Reference limit: weak forces the minimum, a program beats the pin
    function automatic int exp_lim();
        if (level == 2'h1) return 100;
        if (prog != 0) return lim_tab[code];
        return config_pin_one ? 500 : 100;
    endfunction : exp_lim

    // Filter plus state plus output register, with margin
    task check_mode;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(charge_state, level == 0 ? CS_TRICKLE : level == 1 ? CS_WEAK : CS_FAST);
        if (level != 2'h0) chk(active_limit_ma, exp_lim());
        if (level == 2'h2) chk(input_limited_flag, exp_lim() < 500);
        if (level == 2'h2) chk(main_charge_ma, exp_lim() < 500 ? exp_lim() : 500);
        if (level == 2'h1) chk(trickle_branch_ma, 20);
        if (level == 2'h1) chk(main_charge_ma, 80);
        if (level == 2'h0) chk({iso_switch_on, ldo_holds_system}, 2'h1);
        @(posedge clk_sys);
        $display("test mode %0d done", level);
    endtask : check_mode

    initial begin
        rst = 1'b1; config_pin_one = 1'b0; level = 2'h2; awaddr = '0; araddr = '0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        wdata = '0; wstrb = 4'hF; n_fail = 0; num_checks = 0; prog = 0; code = 0;
        void'($urandom(32'h56cfc682));
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(active_limit_ma, MA_100);
        chk(charge_state, CS_OFF);
        @(posedge clk_sys);
        rst <= 1'b0;
        check_mode();
        config_pin_one <= 1'b1;
        check_mode();
        // Sticky events held back by a zero mask, then enabled, then cleared
        @(negedge clk_sys);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h7);
        @(negedge clk_sys);
        chk(irq, 1'b1);
        wr(ADDR_IRQ_STAT, 32'h7);
        rd(ADDR_IRQ_STAT);
        @(negedge clk_sys);
        chk({rd_data[2:0], irq}, 4'h0);
        wr(ADDR_IRQ_MASK, 32'h0);
        level <= 2'h0;
        check_mode();
        level <= 2'h1;
        check_mode();
        level <= 2'h2;
        check_mode();
        for (int i = 0; i < 6; i++) begin
            code = i;
            prog = 1;
            wr(ADDR_CTRL, ($urandom() & 32'hFFFFFF00) | 32'(i));
            check_mode();
            rd(ADDR_STATUS);
            chk(rd_data[26:16], lim_tab[i]);
        end
        config_pin_one <= 1'b0;
        check_mode();
        level <= 2'h1;
        check_mode();
        // Dead cell held past the short time-out
        level <= 2'h0;
        repeat (80) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(charge_state, CS_FAULT);
        wr(ADDR_CONFIG, 32'h1);
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(charge_state, CS_OFF);
        wr(ADDR_CONFIG, 32'h3);
        check_mode();
        rd(8'h18);
        chk(resp, RESP_SLVERR);
        chk(rd_data, 32'h0);
        wr(8'h1C, 32'h5);
        chk(resp, RESP_SLVERR);
        $display("test bus done");
        close_out();
    end
endmodule : tb_charge_mode_controller
